// ==== psfc_regs.svh ====
// Purpose: offsets, field positions, reset values and timing figures of the port selector and pixel clock meter
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef PSFC_REGS_SVH
`define PSFC_REGS_SVH

`define PSFC_SEL_OFFSET      8'h1e
`define PSFC_METER_OFFSET    8'h1f
`define PSFC_SEL_WIDTH       3
`define PSFC_SEL_RESET       3'h1
`define PSFC_SEL_EN_BIT      2
`define PSFC_SEL_ALT_BIT     1
`define PSFC_SEL_MAIN_BIT    0
`define PSFC_METER_RESET     8'h00
`define PSFC_COUNT_MAX       8'hff
`define PSFC_SEC_ADDR_INC    7'h01
`define PSFC_OSC_PERIOD_NS   40

`endif

// ==== psfc_pkg.sv ====
// Purpose: shared types of the port selector and pixel clock meter
// Assumes: nothing
// Notes:   constants live in psfc_regs.svh
package psfc_pkg;
    typedef logic [7:0] psfc_byte_t;
    typedef logic [1:0] psfc_link_mask_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_ACK,
        ST_RD,
        ST_RACK
    } psfc_state_e;
endpackage

// ==== psfc_meter_if.sv ====
// Purpose: carries the meter start, window and result between the top and the meter
// Assumes: one clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/1ps
interface psfc_meter_if;
    logic                 start;
    psfc_pkg::psfc_byte_t window;
    psfc_pkg::psfc_byte_t count;
    logic                 busy;
    modport ctrl  (output start, output window, input count, input busy);
    modport meter (input start, input window, output count, output busy);
endinterface

// ==== psfc_freq_meter.sv ====
// Purpose: counts pixel clock rising edges over a window of oscillator clock periods
// Assumes: pix_clk_in and osc_clk_in are sampled levels, each well below half of sys_clk
// Notes:   a pixel clock above about 25 MHz aliases; the result is only a rough estimate
`timescale 1ns/1ps
`include "psfc_regs.svh"
module psfc_freq_meter (
    input  wire logic  sys_clk,
    input  wire logic  rst,
    input  wire logic  pix_clk_in,
    input  wire logic  osc_clk_in,
    psfc_meter_if.meter m
);
    import psfc_pkg::*;

    logic       pix_prev_reg;
    logic       osc_prev_reg;
    psfc_byte_t remain_reg;
    logic       pix_rise;
    logic       osc_rise;

    assign pix_rise = pix_clk_in & ~pix_prev_reg;
    assign osc_rise = osc_clk_in & ~osc_prev_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pix_prev_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            pix_prev_reg <= pix_clk_in;
            osc_prev_reg <= osc_clk_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // a write restarts at once, even in the middle of a window
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            m.count    <= `PSFC_METER_RESET;
            remain_reg <= 8'h00;
            m.busy     <= 1'b0;
        end else if (m.start) begin
            m.count    <= 8'h00;
            remain_reg <= m.window;
            m.busy     <= (m.window != 8'h00);
        end else if (m.busy) begin
            if (pix_rise && m.count != `PSFC_COUNT_MAX) begin
                m.count <= m.count + 8'h01;
            end
            if (osc_rise) begin
                remain_reg <= remain_reg - 8'h01;
                if (remain_reg == 8'h01) begin
                    m.busy <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_meter_clear: assert property (@(posedge sys_clk) disable iff (rst)
        m.start |=> (m.count == 8'h00 && m.busy == ($past(m.window) != 8'h00)))
        else $error("meter did not clear on start");

    a_meter_saturate: assert property (@(posedge sys_clk) disable iff (rst)
        (m.count == 8'hff && !m.start) |=> m.count == 8'hff)
        else $error("meter count wrapped");

    a_meter_window: assert property (@(posedge sys_clk) disable iff (rst)
        (m.busy && !m.start && !(osc_rise && remain_reg == 8'h01)) |=> m.busy)
        else $error("meter window ended early");

    a_meter_frozen: assert property (@(posedge sys_clk) disable iff (rst)
        (!m.busy && !m.start) |=> $stable(m.count))
        else $error("meter count moved outside window");

endmodule // psfc_freq_meter

// ==== psfc_top.sv ====
// Purpose: i2c target that steers register accesses to link 0, link 1 and shared registers, plus pixel meter
// Assumes: scl_in and sda_in are synchronous to sys_clk; link register data is combinational on acc_addr
// Notes:   writes auto-increment the pointer; reads return the byte at the pointer
//
// Notes on behaviour
// - with the second-address enable set, the target also answers its base address plus one (7-bit).
// - accesses through that second address go to link 1 and the shared registers.
// - with alternate select set, primary-address writes update link 1 and the shared registers.
// - with alternate select set, primary-address reads return link 1 and the shared registers.
// - with only main select set, primary-address writes and reads go to link 0 and the shared registers.
// - with both selects set, primary-address reads return link 1.
// - both select bits are ignored while the second-address enable is set.
// - writing the meter register counts pixel edges over the written number of oscillator periods.
// - reading the meter register returns the edge count of the latest window.
// - the edge count stops at 0xff rather than wrapping.
`timescale 1ns/1ps
`include "psfc_regs.svh"
module psfc_top (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    output logic                           sda_out,
    output logic                           sda_oe,
    input  wire logic [6:0]                base_target_address,
    input  wire logic                      pix_clk_in,
    input  wire logic                      osc_clk_in,
    output psfc_pkg::psfc_byte_t           acc_addr,
    output psfc_pkg::psfc_byte_t           acc_wdata,
    output logic                           acc_wr,
    output logic                           acc_rd,
    output psfc_pkg::psfc_link_mask_t      acc_link_mask,
    output logic                           acc_rd_link1,
    input  wire psfc_pkg::psfc_byte_t      link0_rdata,
    input  wire psfc_pkg::psfc_byte_t      link1_rdata
);
    import psfc_pkg::*;

    psfc_state_e                 state_reg;
    psfc_state_e                 after_reg;
    logic [2:0]                  bit_cnt_reg;
    psfc_byte_t                  shift_reg;
    psfc_byte_t                  ptr_reg;
    logic                        sec_hit_reg;
    logic                        ptr_inc_reg;
    logic                        rd_go_reg;
    logic                        sda_oe_reg;
    logic                        scl_prev_reg;
    logic                        sda_prev_reg;
    logic [`PSFC_SEL_WIDTH-1:0]  sel_reg;
    logic [6:0]                  sec_addr;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        bus_start;
    logic                        bus_stop;
    logic                        byte_done;
    psfc_byte_t                  rx_byte;
    psfc_byte_t                  rd_byte;
    logic                        rd_load;
    logic                        hit_primary;
    logic                        hit_secondary;
    logic                        sec_en;
    logic                        alt_sel;
    logic                        main_sel;

    psfc_meter_if meter_bus ();
    psfc_freq_meter u_meter (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .pix_clk_in (pix_clk_in),
        .osc_clk_in (osc_clk_in),
        .m          (meter_bus.meter)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus events
    assign scl_rise  = scl_in & ~scl_prev_reg;
    assign scl_fall  = ~scl_in & scl_prev_reg;
    assign bus_start = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
    assign bus_stop  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
    assign rx_byte   = {shift_reg[6:0], sda_in};
    assign byte_done = scl_rise && bit_cnt_reg == 3'd7
                       && (state_reg == ST_ADDR || state_reg == ST_PTR || state_reg == ST_WDATA);
    assign rd_load   = state_reg == ST_ACK && scl_fall && sda_oe_reg && after_reg == ST_RD;
    assign sec_en        = sel_reg[`PSFC_SEL_EN_BIT];
    assign alt_sel       = sel_reg[`PSFC_SEL_ALT_BIT];
    assign main_sel      = sel_reg[`PSFC_SEL_MAIN_BIT];
    assign sec_addr      = base_target_address + `PSFC_SEC_ADDR_INC;
    assign hit_primary   = shift_reg[6:0] == base_target_address;
    assign hit_secondary = sec_en && shift_reg[6:0] == sec_addr;
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_reg;
    assign acc_addr = ptr_reg;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_in;
            sda_prev_reg <= sda_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link steering
    always_comb begin
        if (sec_hit_reg) begin
            acc_link_mask = 2'b10;
            acc_rd_link1  = 1'b1;
        end else if (sec_en) begin
            acc_link_mask = 2'b01;
            acc_rd_link1  = 1'b0;
        end else begin
            // neither select set falls back to link 0
            acc_link_mask = {alt_sel, main_sel | ~alt_sel};
            acc_rd_link1  = alt_sel;
        end
    end
    always_comb begin
        if (ptr_reg == `PSFC_SEL_OFFSET) begin
            rd_byte = {5'h00, sel_reg};
        end else if (ptr_reg == `PSFC_METER_OFFSET) begin
            rd_byte = meter_bus.count;
        end else if (acc_rd_link1) begin
            rd_byte = link1_rdata;
        end else begin
            rd_byte = link0_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // target state machine; start and stop override any state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            after_reg   <= ST_IDLE;
            bit_cnt_reg <= 3'd0;
            shift_reg   <= 8'h00;
            ptr_reg     <= 8'h00;
            sec_hit_reg <= 1'b0;
            ptr_inc_reg <= 1'b0;
            rd_go_reg   <= 1'b0;
            sda_oe_reg  <= 1'b0;
        end else if (bus_start) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 3'd0;
            sda_oe_reg  <= 1'b0;
        end else if (bus_stop) begin
            state_reg  <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_reg   <= rx_byte;
                        bit_cnt_reg <= bit_cnt_reg + 3'd1;
                    end
                    if (byte_done) begin
                        ptr_inc_reg <= state_reg == ST_WDATA;
                        state_reg   <= ST_ACK;
                        after_reg   <= ST_WDATA;
                        if (state_reg == ST_ADDR) begin
                            // unmatched address: stay off the bus until the next start
                            if (!(hit_primary || hit_secondary)) begin
                                state_reg <= ST_IDLE;
                            end
                            sec_hit_reg <= hit_secondary && !hit_primary;
                            after_reg   <= sda_in ? ST_RD : ST_PTR;
                        end else if (state_reg == ST_PTR) begin
                            ptr_reg   <= rx_byte;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        sda_oe_reg <= !sda_oe_reg;
                        if (sda_oe_reg) begin
                            state_reg   <= after_reg;
                            bit_cnt_reg <= 3'd0;
                            if (ptr_inc_reg) begin
                                ptr_reg <= ptr_reg + 8'h01;
                            end
                            if (after_reg == ST_RD) begin
                                shift_reg  <= rd_byte;
                                sda_oe_reg <= ~rd_byte[7];
                            end
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'd1;
                        if (bit_cnt_reg == 3'd7) begin
                            state_reg <= ST_RACK;
                        end
                    end else if (scl_fall) begin
                        shift_reg  <= {shift_reg[6:0], 1'b0};
                        sda_oe_reg <= ~shift_reg[6];
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        // a not-acknowledge ends the read burst
                        if (sda_in) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            rd_go_reg <= 1'b1;
                            ptr_reg   <= ptr_reg + 8'h01;
                        end
                    end else if (scl_fall) begin
                        sda_oe_reg <= 1'b0;
                        if (rd_go_reg) begin
                            rd_go_reg   <= 1'b0;
                            state_reg   <= ST_RD;
                            bit_cnt_reg <= 3'd0;
                            shift_reg   <= rd_byte;
                            sda_oe_reg  <= ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    state_reg  <= ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // local registers and outgoing strobes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_reg <= `PSFC_SEL_RESET;
        end else if (byte_done && state_reg == ST_WDATA && ptr_reg == `PSFC_SEL_OFFSET) begin
            sel_reg <= rx_byte[`PSFC_SEL_WIDTH-1:0];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meter_bus.start  <= 1'b0;
            meter_bus.window <= `PSFC_METER_RESET;
        end else begin
            meter_bus.start <= byte_done && state_reg == ST_WDATA && ptr_reg == `PSFC_METER_OFFSET;
            if (byte_done && state_reg == ST_WDATA && ptr_reg == `PSFC_METER_OFFSET) begin
                meter_bus.window <= rx_byte;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_wr    <= 1'b0;
            acc_rd    <= 1'b0;
            acc_wdata <= 8'h00;
        end else begin
            acc_wr <= byte_done && state_reg == ST_WDATA
                      && ptr_reg != `PSFC_SEL_OFFSET && ptr_reg != `PSFC_METER_OFFSET;
            acc_rd <= rd_load || (state_reg == ST_RACK && scl_fall && rd_go_reg);
            if (byte_done && state_reg == ST_WDATA) begin
                acc_wdata <= rx_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_sec_addr_ack: assert property (@(posedge sys_clk) disable iff (rst)
        (byte_done && !bus_start && !bus_stop && state_reg == ST_ADDR && sec_en && shift_reg[6:0] == sec_addr)
        |=> (state_reg == ST_ACK && sec_hit_reg))
        else $error("second address not acknowledged");
    a_sec_addr_off: assert property (@(posedge sys_clk) disable iff (rst)
        (byte_done && !bus_start && !bus_stop && state_reg == ST_ADDR && !sec_en && !hit_primary)
        |=> state_reg == ST_IDLE)
        else $error("address answered while disabled");
    a_sec_route: assert property (@(posedge sys_clk) disable iff (rst)
        sec_hit_reg |-> (acc_link_mask == 2'b10 && acc_rd_link1))
        else $error("second address not routed to link 1");
    a_alt_write: assert property (@(posedge sys_clk) disable iff (rst)
        (!sec_hit_reg && !sec_en && alt_sel) |-> acc_link_mask[1])
        else $error("alternate select write misses link 1");
    a_alt_read: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_load && !sec_hit_reg && !sec_en && alt_sel && ptr_reg < `PSFC_SEL_OFFSET)
        |=> shift_reg == $past(link1_rdata))
        else $error("alternate select read not from link 1");
    a_main_route: assert property (@(posedge sys_clk) disable iff (rst)
        (!sec_hit_reg && !sec_en && main_sel && !alt_sel) |-> (acc_link_mask == 2'b01 && !acc_rd_link1))
        else $error("main select not routed to link 0");
    a_both_read: assert property (@(posedge sys_clk) disable iff (rst)
        (!sec_hit_reg && !sec_en && main_sel && alt_sel) |-> (acc_rd_link1 && acc_link_mask == 2'b11))
        else $error("both selects do not read link 1");
    a_select_ignored: assert property (@(posedge sys_clk) disable iff (rst)
        (!sec_hit_reg && sec_en) |-> (acc_link_mask == 2'b01 && !acc_rd_link1))
        else $error("select bits acted while second address enabled");
    a_meter_read: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_load && ptr_reg == `PSFC_METER_OFFSET) |=> shift_reg == $past(meter_bus.count))
        else $error("meter read returned wrong value");
endmodule // psfc_top

// ==== psfc_i2c_host.sv ====
// Purpose: behavioural i2c host that reaches the target's registers
// Assumes: sda is open drain with a pull-up, resolved in the bench
// Notes:   a bit lasts 8 sys_clk cycles, scl low 4 and high 4
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module psfc_i2c_host (
    input  wire logic sys_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // sda moves only while scl is low, so no bit looks like start or stop
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_drv = b;
        tick(2);
        scl = 1'b1;
        tick(2);
        r = sda_line;
        tick(2);
        scl = 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask
    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ack);
        logic a1, a2, a3;
        start();
        byte_out({a, 1'b0}, a1);
        byte_out(p, a2);
        byte_out(d, a3);
        stop();
        ack = a1 & a2 & a3;
    endtask
    // the pointer is written first, then a repeated start turns the bus round
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ack);
        logic a1, a2, a3, r;
        start();
        byte_out({a, 1'b0}, a1);
        byte_out(p, a2);
        start();
        byte_out({a, 1'b1}, a3);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
        stop();
        ack = a1 & a2 & a3;
    endtask
endmodule // psfc_i2c_host

// ==== tb.sv ====
// Purpose: self-checking bench for port steering and the pixel clock meter
// Assumes: link read data is a fixed function of the pointer
// Notes:   meter clocks are generated as sampled levels at or below half of sys_clk
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module tb;
    import psfc_pkg::*;
    logic            sys_clk = 1'b0;
    logic            rst = 1'b1;
    logic            scl, sda_drv, sda_out, sda_oe, acc_wr, acc_rd, acc_rd_link1;
    logic            pix_clk = 1'b0;
    logic            osc_clk = 1'b0;
    logic [6:0]      base;
    psfc_byte_t      acc_addr, acc_wdata;
    psfc_link_mask_t acc_link_mask;
    logic [17:0]     wr_q[$];
    logic [7:0]      rd_q[$];
    int              err_count = 0;
    int              samples_checked = 0;
    int              seed = 32'h1700177d;
    int              cycles = 0;
    int              pix_half = 3;
    int              osc_half = 4;
    wire             sda_in = sda_drv & ~sda_oe;
    psfc_top psfc_top_i (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .base_target_address(base), .pix_clk_in(pix_clk), .osc_clk_in(osc_clk),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_wr(acc_wr), .acc_rd(acc_rd),
        .acc_link_mask(acc_link_mask), .acc_rd_link1(acc_rd_link1),
        .link0_rdata(acc_addr ^ 8'h5a), .link1_rdata(acc_addr ^ 8'ha5));
    psfc_i2c_host psfc_i2c_host_i (.sys_clk(sys_clk), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));
    always #10 sys_clk = ~sys_clk;
    always begin
        repeat (pix_half) @(posedge sys_clk);
        #1 pix_clk = ~pix_clk;
    end
    always begin
        repeat (osc_half) @(posedge sys_clk);
        #1 osc_clk = ~osc_clk;
    end
    always @(posedge sys_clk) begin
        if (acc_wr === 1'b1) wr_q.push_back({acc_addr, acc_wdata, acc_link_mask});
        if (acc_rd === 1'b1) rd_q.push_back(acc_addr);
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // reference routing: second address or enable set bypasses both selects
    function automatic logic [1:0] ref_mask(input logic sec, input logic [2:0] s);
        if (sec) return 2'b10;
        if (s[2] || !s[1]) return 2'b01;
        return s[0] ? 2'b11 : 2'b10;
    endfunction
    task automatic reg_wr(input logic sec, input logic [7:0] p, input logic [7:0] d, input logic [2:0] s);
        logic ack;
        logic ok;
        wr_q.delete();
        ok = !(sec && !s[2]);
        psfc_i2c_host_i.wr(base + {6'h0, sec}, p, d, ack);
        chk({17'h0, ack}, {17'h0, ok});
        if (ok && p < 8'h1e) chk(wr_q.size() == 1 ? wr_q[0] : 18'h0, {p, d, ref_mask(sec, s)});
        else chk(18'(wr_q.size()), 18'h0);
    endtask
    // an answered read gives one read strobe at the pointer; sda_out must stay low (open drain)
    task automatic reg_rd(input logic sec, input logic ok, input logic [7:0] p, output logic [7:0] d);
        logic ack;
        rd_q.delete();
        psfc_i2c_host_i.rd(base + {6'h0, sec}, p, d, ack);
        chk({sda_out, ack, 8'(rd_q.size()), rd_q.size() > 0 ? rd_q[0] : 8'h00}, {1'b0, ok, 7'h0, ok, ok ? p : 8'h00});
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] p, d, dat, e;
        logic [2:0] s;
        logic [1:0] m;
        int         mn[3];
        int         ph[3];
        mn = '{255, 10, 0};
        ph = '{1, 3, 3};
        base = 7'($random(seed)) & 7'h7e;
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge sys_clk);
        reg_rd(1'b0, 1'b1, 8'h1e, d);
        chk(d, 18'h01);
        reg_rd(1'b0, 1'b1, 8'h1f, d);
        chk(d, 18'h00);
        for (int i = 0; i < 8; i++) begin
            s = i[2:0];
            reg_wr(1'b0, 8'h1e, {5'h1f, s}, s);
            reg_rd(1'b0, 1'b1, 8'h1e, d);
            chk(d, {15'h0, s}); // reserved bits read as zero
            for (int k = 0; k < 2; k++) begin
                p = 8'($random(seed)) & 8'h1f;
                if (p >= 8'h1e) p = p - 8'h10;
                dat = 8'($random(seed));
                reg_wr(k[0], p, dat, s);
                reg_rd(k[0], !(k == 1 && !s[2]), p, d);
                m = ref_mask(k[0], s);
                e = m[1] ? (p ^ 8'ha5) : (p ^ 8'h5a);
                if (k == 1 && !s[2]) e = 8'hff; // unanswered address leaves sda to the pull-up
                chk(d, e);
            end
        end
        // saturating case first, so a stale count would show in the next
        for (int j = 0; j < 3; j++) begin
            pix_half = ph[j];
            reg_wr(1'b0, 8'h1f, 8'(mn[j]), 3'h1);
            repeat (mn[j] * osc_half * 2 + 50) @(posedge sys_clk);
            reg_rd(1'b0, 1'b1, 8'h1f, d);
            e = (mn[j] * osc_half / ph[j] > 255) ? 8'hff : 8'(mn[j] * osc_half / ph[j]);
            if (e != 8'hff && e != 8'h00 && (d == e + 8'h1 || d == e - 8'h1)) e = d; // sampling jitter of one edge
            chk(d, e);
        end
        summarize();
    end
endmodule // tb
